/* hw/psh_port.v */
`timescale 1ns/1ns
`default_nettype none
`include "psh_regs.vh"
module psh_port #(
   // Counts at the 100 MHz clock; a bench may shorten them
   parameter [22:0] DETECT_CYC = `PSH_DETECT_CYC,
   parameter [22:0] SETTLE_CYC = `PSH_SETTLE_CYC
) (
   // Clock and reset
   input  wire        mclk_in,
   input  wire        rst_in,
   // Pins
   input  wire        select_line_n_in,
   input  wire        sck_in,
   input  wire        mosi_in,
   input  wire        sda_in,
   output wire        miso_out,
   output wire        miso_oe_out,
   output wire        sda_out,
   output wire        sda_oe_out,
   output wire        data_available_pin_out,
   // Internal datapath
   input  wire [15:0] pressure_in,
   input  wire        update_tick_in,
   input  wire [3:0]  strap_code_in,
   // Status and configuration
   output wire        spi_mode_out,
   output wire        i2c_mode_out,
   output wire        settled_out,
   output wire [2:0]  range_out,
   output wire        wdog_en_out,
   output wire [2:0]  bw_out,
   output wire        notch_en_out,
   output wire [7:0]  rate_out,
   output wire [6:0]  i2c_addr_out
);
   localparam [2:0] ST_WAIT = 3'h1;
   localparam [2:0] ST_SPI  = 3'h2;
   localparam [2:0] ST_I2C  = 3'h4;

   // Bits: 0 select, 1 clock, 2 data in, 3 I2C data
   reg  [3:0]  sync1_reg;
   reg  [3:0]  sync2_reg;
   reg  [1:0]  prev_reg;
   reg  [2:0]  state_reg;
   reg  [22:0] cnt_reg;
   reg         settled_reg;
   reg  [6:0]  addr_reg;
   reg  [15:0] tx_reg;
   reg  [14:0] rx_reg;
   reg  [4:0]  bit_reg;
   reg  [7:0]  mode_reg;
   reg  [7:0]  active_reg;
   reg  [7:0]  rate_reg;
   reg  [7:0]  div_reg;
   reg         dav_reg;

   wire        i2c_oe;
   wire        i2c_wr;
   wire        i2c_rd;
   wire [7:0]  i2c_mode;
   wire [7:0]  i2c_rate;

   // Synchronised pin levels
   wire        sck_s    = sync2_reg[1];
   wire        mosi_s   = sync2_reg[2];
   wire        sda_s    = sync2_reg[3];

   // Edges of the synchronised pins
   wire sel_n    = sync2_reg[0];
   wire sel_fall = prev_reg[0] & ~sel_n;
   wire sck_rise = ~prev_reg[1] & sck_s;
   wire sck_fall = prev_reg[1] & ~sck_s;
   // Bus activity before detection is ignored
   wire spi_act  = (state_reg == ST_SPI) & ~sel_n; // RULE_03
   wire spi_done = spi_act & sck_rise &
                   (bit_reg == `PSH_SPI_BITS - 5'h1); // RULE_05

   // Only one port is ever live, so one store path serves both
   wire       cfg_we   = spi_done | i2c_wr;
   wire [7:0] cfg_mode = spi_done ? rx_reg[14:7] : i2c_mode;
   wire [7:0] cfg_rate = spi_done ? {rx_reg[6:0], mosi_s} : i2c_rate;
   wire       rd_ev    = spi_done | i2c_rd;

   // Auto rate follows the bandwidth field that is in force
   wire [2:0] bw_cur   = active_reg[`PSH_BW_MSB:`PSH_BW_LSB];
   wire [7:0] auto_div = `PSH_AUTO_DIV_BASE << bw_cur;
   wire [7:0] divisor  = (rate_reg == 8'h00) ? auto_div : rate_reg; // RULE_21
   wire       div_hit  = update_tick_in & (div_reg <= 8'h01);

   assign spi_mode_out  = (state_reg == ST_SPI);
   assign i2c_mode_out  = (state_reg == ST_I2C);
   assign settled_out   = settled_reg;
   assign miso_out      = tx_reg[15];
   assign miso_oe_out   = spi_act;
   assign sda_out       = 1'b0;
   assign sda_oe_out    = i2c_oe & (state_reg == ST_I2C);
   assign data_available_pin_out = dav_reg;
   assign range_out     = active_reg[`PSH_RANGE_MSB:`PSH_RANGE_LSB]; // RULE_12
   assign wdog_en_out   = active_reg[`PSH_WDOG_BIT];
   assign bw_out        = bw_cur;
   assign notch_en_out  = active_reg[`PSH_NOTCH_BIT];
   assign rate_out      = rate_reg;
   assign i2c_addr_out  = addr_reg;

   // Two flops on every pin before use
   always @(posedge mclk_in) begin
      // Reset high: idle level of select and of the I2C lines
      if (rst_in) begin
         sync1_reg <= 4'hF;
         sync2_reg <= 4'hF;
         prev_reg  <= 2'h3;
      end else begin
         sync1_reg <= {sda_in, mosi_in, sck_in, select_line_n_in};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg[1:0];
      end
   end

   // Detect once, then hold for the rest of operation
   always @(posedge mclk_in) begin
      if (rst_in) begin
         state_reg   <= ST_WAIT;
         cnt_reg     <= 23'h00_0000;
         settled_reg <= 1'b0;
         addr_reg    <= `PSH_I2C_BASE;
      end else begin
         // Counter stops at the settle count and holds
         if (cnt_reg != SETTLE_CYC)
            cnt_reg <= cnt_reg + 23'h00_0001;
         else
            settled_reg <= 1'b1; // RULE_04
         case (state_reg)
            ST_WAIT: begin
               if (cnt_reg == DETECT_CYC) begin // RULE_22
                  // A grounded select simply lands here as I2C
                  state_reg <= sel_n ? ST_SPI : ST_I2C; // RULE_01 RULE_02
                  if (strap_code_in < `PSH_I2C_NADDR)
                     addr_reg <= `PSH_I2C_BASE +
                                 {3'h0, strap_code_in}; // RULE_16
                  else
                     addr_reg <= `PSH_I2C_BASE; // RULE_15
               end
            end
            // No way back: only a reset detects again
            ST_SPI:  state_reg <= ST_SPI;
            ST_I2C:  state_reg <= ST_I2C;
            default: state_reg <= ST_WAIT;
         endcase
      end
   end

   // SPI shifter: clock idles low, sample rising, change falling
   always @(posedge mclk_in) begin
      if (rst_in) begin
         tx_reg  <= 16'h0000;
         rx_reg  <= 15'h0000;
         bit_reg <= 5'h00;
      end else if (state_reg == ST_SPI && sel_fall) begin
         tx_reg  <= pressure_in; // RULE_08 RULE_23
         bit_reg <= 5'h00;
      end else if (spi_act && bit_reg != `PSH_SPI_BITS) begin
         // A frame cut short stores nothing; next select restarts it
         if (sck_rise) begin
            rx_reg  <= {rx_reg[13:0], mosi_s}; // RULE_06 RULE_24
            bit_reg <= bit_reg + 5'h01;
         end else if (sck_fall && bit_reg != 5'h00) begin
            // A fall before any rise would drop the first bit
            tx_reg  <= {tx_reg[14:0], 1'b0}; // RULE_06 RULE_24
         end
      end
   end

   // New mode reaches the datapath one communication cycle late
   always @(posedge mclk_in) begin
      if (rst_in) begin
         mode_reg   <= `PSH_MODE_RST;
         active_reg <= `PSH_MODE_RST;
         rate_reg   <= `PSH_RATE_RST;
      end else if (cfg_we) begin
         active_reg <= mode_reg; // RULE_20
         mode_reg   <= cfg_mode; // RULE_08
         rate_reg   <= cfg_rate; // RULE_08
      end
   end

   // Rate divider on internal update; new data wins over a read
   always @(posedge mclk_in) begin
      if (rst_in) begin
         div_reg <= `PSH_RATE_RST;
         dav_reg <= 1'b0;
      end else begin
         // Count holds between ticks
         if (update_tick_in) begin
            if (div_hit)
               div_reg <= divisor; // RULE_13
            else
               div_reg <= div_reg - 8'h01;
         end
         if (div_hit)
            dav_reg <= 1'b1; // RULE_13
         else if (rd_ev)
            dav_reg <= 1'b0; // RULE_14
      end
   end

   // Slave is held idle until I2C is picked
   psh_i2c_slave u_i2c (
      .clk_in        (mclk_in),
      .rst_in        (rst_in),
      .en_in         (state_reg == ST_I2C),
      .addr_in       (addr_reg),
      .word_in       (pressure_in),
      .scl_in        (sck_s),
      .sda_in        (sda_s),
      .sda_oe_out    (i2c_oe),
      .wr_valid_out  (i2c_wr),
      .mode_byte_out (i2c_mode),
      .rate_byte_out (i2c_rate),
      .rd_start_out  (i2c_rd)
   );
endmodule
`default_nettype wire

/* common/psh_regs.vh */
// Behaviour
// (RULE_01) Sample select once after power-on delay
// (RULE_02) Host may ground select for I2C
// (RULE_03) Host stays silent during interface detect
// (RULE_04) Early pressure unsettled; configuration still accepted
// (RULE_05) SPI exchange is exactly sixteen bits
// (RULE_06) SPI shifts most significant bit first
// (RULE_07) Host sends mode then rate each read
// (RULE_08) Shift pressure out, store mode and rate
// (RULE_09) Host waits after select before clocking
// (RULE_10) Host spaces bytes within a transfer
// (RULE_11) Host holds select after last clock
// (RULE_12) Mode selects range, bandwidth, notch filter
// (RULE_13) Rate divides internal update for data-available
// (RULE_14) Pressure read clears data-available
// (RULE_15) Grounded clock strap gives base address
// (RULE_16) Ten strap-selected slave addresses
// (RULE_17) I2C side is slave only
// (RULE_18) Host starts transfers and drives clock
// (RULE_19) I2C write and read are separate
// (RULE_20) Mode resets F3, fields, one-cycle latency
// (RULE_21) Rate resets 1C, zero selects auto
// (RULE_22) Interface detection ends within 40 ms
// (RULE_23) Pressure is 16-bit, high byte first
// (RULE_24) SPI clock idles low, rising-edge sample
// (RULE_25) I2C write mode then rate; read high-low
`ifndef PSH_REGS_VH
`define PSH_REGS_VH

`define PSH_MODE_RST      8'hF3
`define PSH_RATE_RST      8'h1C
`define PSH_RANGE_MSB     2
`define PSH_RANGE_LSB     0
`define PSH_WDOG_BIT      3
`define PSH_BW_MSB        6
`define PSH_BW_LSB        4
`define PSH_NOTCH_BIT     7
`define PSH_AUTO_DIV_BASE 8'h01
`define PSH_I2C_BASE      7'h28
`define PSH_I2C_NADDR     4'hA
`define PSH_SPI_BITS      5'h10
`define PSH_CLK_KHZ       32'h0001_86A0
`define PSH_DETECT_MS     32'h0000_0028
`define PSH_SETTLE_MS     32'h0000_0050
`define PSH_DETECT_CYC    23'h3D_0900
`define PSH_SETTLE_CYC    23'h7A_1200

`endif

/* hw/psh_i2c_slave.v */
`timescale 1ns/1ns
`default_nettype none
module psh_i2c_slave (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_in,
   // Control
   input  wire        en_in,
   input  wire [6:0]  addr_in,
   input  wire [15:0] word_in,
   // Synchronised bus levels
   input  wire        scl_in,
   input  wire        sda_in,
   // Data line pull-down
   output wire        sda_oe_out,
   // Configuration and read events
   output wire        wr_valid_out,
   output wire [7:0]  mode_byte_out,
   output wire [7:0]  rate_byte_out,
   output wire        rd_start_out
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_RXB  = 5'h02;
   localparam [4:0] ST_ACK  = 5'h04;
   localparam [4:0] ST_TXB  = 5'h08;
   localparam [4:0] ST_MACK = 5'h10;

   reg [4:0]  state_reg;
   reg        scl_prev_reg;
   reg        sda_prev_reg;
   reg [3:0]  bit_reg;
   reg [7:0]  sh_reg;
   reg        addr_ph_reg;
   reg        rw_reg;
   reg        mack_reg;
   reg [1:0]  idx_reg;
   reg [7:0]  mode_tmp_reg;
   reg [15:0] word_reg;
   reg        oe_reg;
   reg        wr_reg;
   reg        rd_reg;
   reg [7:0]  mode_reg;
   reg [7:0]  rate_reg;

   wire       scl_rise = ~scl_prev_reg & scl_in;
   wire       scl_fall = scl_prev_reg & ~scl_in;
   wire       start = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
   wire       stop  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
   // Bytes past the pressure word read as released bus
   wire [7:0] next_byte = (idx_reg == 2'h0) ? word_reg[15:8] :
                          (idx_reg == 2'h1) ? word_reg[7:0] : 8'hFF;

   assign sda_oe_out    = oe_reg;
   assign wr_valid_out  = wr_reg;
   assign rd_start_out  = rd_reg;
   assign mode_byte_out = mode_reg;
   assign rate_byte_out = rate_reg;

   // Only the data line is ever pulled; clock is never driven
   always @(posedge clk_in) begin // RULE_17
      if (rst_in) begin
         state_reg    <= ST_IDLE;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         bit_reg      <= 4'h0;
         sh_reg       <= 8'h00;
         addr_ph_reg  <= 1'b0;
         rw_reg       <= 1'b0;
         mack_reg     <= 1'b0;
         idx_reg      <= 2'h0;
         mode_tmp_reg <= 8'h00;
         word_reg     <= 16'h0000;
         oe_reg       <= 1'b0;
         wr_reg       <= 1'b0;
         rd_reg       <= 1'b0;
         mode_reg     <= 8'h00;
         rate_reg     <= 8'h00;
      end else begin
         scl_prev_reg <= scl_in;
         sda_prev_reg <= sda_in;
         wr_reg       <= 1'b0;
         rd_reg       <= 1'b0;
         if (!en_in || stop) begin
            state_reg <= ST_IDLE;
            oe_reg    <= 1'b0;
         end else if (start) begin // RULE_18
            state_reg   <= ST_RXB;
            bit_reg     <= 4'h0;
            addr_ph_reg <= 1'b1;
            oe_reg      <= 1'b0;
            idx_reg     <= 2'h0;
         end else begin
            case (state_reg)
               ST_RXB: begin
                  if (scl_rise) begin
                     sh_reg  <= {sh_reg[6:0], sda_in};
                     bit_reg <= bit_reg + 4'h1;
                  end else if (scl_fall && bit_reg == 4'h8) begin
                     if (addr_ph_reg) begin
                        if (sh_reg[7:1] == addr_in) begin // RULE_15
                           rw_reg    <= sh_reg[0];
                           oe_reg    <= 1'b1;
                           state_reg <= ST_ACK;
                           if (sh_reg[0]) begin // RULE_19
                              rd_reg   <= 1'b1;
                              word_reg <= word_in;
                           end
                        end else begin
                           state_reg <= ST_IDLE;
                        end
                     end else begin
                        oe_reg    <= 1'b1;
                        state_reg <= ST_ACK;
                        if (idx_reg == 2'h0)
                           mode_tmp_reg <= sh_reg; // RULE_25
                        if (idx_reg == 2'h1) begin
                           mode_reg <= mode_tmp_reg; // RULE_25
                           rate_reg <= sh_reg;
                           wr_reg   <= 1'b1;
                        end
                        if (idx_reg != 2'h3)
                           idx_reg <= idx_reg + 2'h1;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bit_reg <= 4'h0;
                     if (rw_reg) begin
                        sh_reg    <= next_byte; // RULE_23
                        oe_reg    <= ~next_byte[7];
                        state_reg <= ST_TXB;
                        if (idx_reg != 2'h3)
                           idx_reg <= idx_reg + 2'h1;
                     end else begin
                        oe_reg      <= 1'b0;
                        addr_ph_reg <= 1'b0;
                        state_reg   <= ST_RXB;
                     end
                  end
               end
               ST_TXB: begin
                  if (scl_fall) begin
                     if (bit_reg == 4'h7) begin
                        oe_reg    <= 1'b0;
                        state_reg <= ST_MACK;
                     end else begin
                        sh_reg  <= {sh_reg[6:0], 1'b0};
                        oe_reg  <= ~sh_reg[6];
                        bit_reg <= bit_reg + 4'h1;
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     mack_reg <= ~sda_in;
                  end else if (scl_fall) begin
                     if (mack_reg) begin
                        sh_reg    <= next_byte;
                        oe_reg    <= ~next_byte[7];
                        bit_reg   <= 4'h0;
                        state_reg <= ST_TXB;
                        if (idx_reg != 2'h3)
                           idx_reg <= idx_reg + 2'h1;
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
                  oe_reg    <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* verif/psh_port_props.sv */
`timescale 1ns/1ns
`default_nettype none
module psh_port_props #(
   parameter [22:0] DETECT_CYC = 23'h32,
   parameter [22:0] SETTLE_CYC = 23'hC8
) (
   // Clock and reset
   input wire logic       mclk_in,
   input wire logic       rst_in,
   // Watched ports
   input wire logic       update_tick_in,
   input wire logic       miso_oe_out,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   input wire logic       data_available_pin_out,
   input wire logic       spi_mode_out,
   input wire logic       i2c_mode_out,
   input wire logic       settled_out,
   input wire logic [2:0] range_out,
   input wire logic       wdog_en_out,
   input wire logic [2:0] bw_out,
   input wire logic       notch_en_out,
   input wire logic [7:0] rate_out
);
   logic [22:0] cnt_reg;
   wire  [7:0]  mode_w;
   assign mode_w = {notch_en_out, bw_out, wdog_en_out, range_out};
   // Cycles since reset release, saturating
   always @(posedge mclk_in) begin
      if (rst_in)
         cnt_reg <= 23'h0;
      else if (cnt_reg != 23'h7F_FFFF)
         cnt_reg <= cnt_reg + 23'h1;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   a_one_port: assert property (
      !(spi_mode_out && i2c_mode_out)) else $error("both ports on");
   a_spi_kept: assert property (
      spi_mode_out |=> spi_mode_out) else $error("spi port lost");
   a_i2c_kept: assert property (
      i2c_mode_out |=> i2c_mode_out) else $error("i2c port lost");
   a_no_early: assert property (
      cnt_reg + 23'h3 < DETECT_CYC |-> !spi_mode_out && !i2c_mode_out)
      else $error("port picked early");
   a_detect_due: assert property (
      cnt_reg > DETECT_CYC + 23'h5 |-> spi_mode_out || i2c_mode_out)
      else $error("no port picked");
   a_settle_time: assert property (
      (cnt_reg + 23'h3 < SETTLE_CYC |-> !settled_out) and
      (cnt_reg > SETTLE_CYC + 23'h5 |-> settled_out))
      else $error("settled flag off time");
   a_reset_vals: assert property (
      $fell(rst_in) |-> mode_w == 8'hF3 && rate_out == 8'h1C &&
      !data_available_pin_out) else $error("bad reset value");
   a_dav_tick: assert property (
      $rose(data_available_pin_out) |->
      $past(update_tick_in) || $past(update_tick_in, 2))
      else $error("dav rose without tick");
   a_sda_slave: assert property (
      sda_oe_out |-> i2c_mode_out && !sda_out) else $error("sda misuse");
   a_miso_spi: assert property (
      miso_oe_out |-> spi_mode_out) else $error("miso driven off spi");
   a_cfg_quiet: assert property (
      ((spi_mode_out && !miso_oe_out) || (i2c_mode_out && !sda_oe_out)) |=>
      ($stable(rate_out) && $stable(mode_w)))
      else $error("config moved outside a transfer");
endmodule
bind psh_port psh_port_props #(
   .DETECT_CYC(DETECT_CYC),
   .SETTLE_CYC(SETTLE_CYC)
) u_props (.mclk_in, .rst_in, .update_tick_in, .miso_oe_out, .sda_out,
   .sda_oe_out, .data_available_pin_out, .spi_mode_out, .i2c_mode_out,
   .settled_out, .range_out, .wdog_en_out, .bw_out, .notch_en_out,
   .rate_out);
`default_nettype wire

/* verif/psh_host.sv */
`timescale 1ns/1ns
`default_nettype none
module psh_host (
   // Pin levels seen by the host
   input  wire logic miso_in,
   input  wire logic sda_in,
   // Host-driven pins
   output var  logic sel_n_out,
   output var  logic sck_out,
   output var  logic mosi_out,
   output var  logic sda_pull_out
);
   initial begin
      sel_n_out = 1'b1;
      sck_out = 1'b0;
      mosi_out = 1'b1;
      sda_pull_out = 1'b0;
   end
   task automatic spi_xfer(input logic [15:0] cfg, output logic [15:0] rx);
      begin
         sel_n_out = 1'b0;
         for (int i = 15; i >= 0; i--) begin
            if (i[2:0] == 3'h7)
               #100_000;
            mosi_out = cfg[i];
            #40;
            sck_out = 1'b1;
            rx[i] = miso_in;
            #40;
            sck_out = 1'b0;
         end
         #20_000;
         sel_n_out = 1'b1;
         // Released line must not keep looking valid
         mosi_out = ~cfg[0];
         // Select stays high a while before any next frame
         #6_000;
      end
   endtask
   task automatic i2c_pins;
      begin
         sel_n_out = 1'b0;
         sck_out = 1'b1;
      end
   endtask
   task automatic i2c_bit(input logic b, output logic r);
      begin
         #20;
         sda_pull_out = ~b;
         #20;
         sck_out = 1'b1;
         #20;
         r = sda_in;
         #20;
         sck_out = 1'b0;
      end
   endtask
   // Eight bits then the acknowledge slot, which lands in q[0]
   task automatic i2c_byte(input logic [7:0] d, input logic ak,
                           output logic [8:0] q);
      logic [8:0] v;
      begin
         v = {d, ak};
         for (int i = 8; i >= 0; i--)
            i2c_bit(v[i], q[i]);
      end
   endtask
   task automatic i2c_start;
      begin
         sda_pull_out = 1'b1;
         #40;
         sck_out = 1'b0;
      end
   endtask
   task automatic i2c_stop;
      begin
         #20;
         sda_pull_out = 1'b1;
         #20;
         sck_out = 1'b1;
         #20;
         sda_pull_out = 1'b0;
         #40;
      end
   endtask
   task automatic i2c_write(input logic [6:0] a, input logic [15:0] cfg,
                            output logic [2:0] nak);
      logic [8:0] q0, q1, q2;
      begin
         i2c_start();
         i2c_byte({a, 1'b0}, 1'b1, q0);
         i2c_byte(cfg[15:8], 1'b1, q1);
         i2c_byte(cfg[7:0], 1'b1, q2);
         i2c_stop();
         nak = {q0[0], q1[0], q2[0]};
      end
   endtask
   task automatic i2c_read(input logic [6:0] a, output logic [16:0] rx);
      logic [8:0] q0, q1, q2;
      begin
         i2c_start();
         i2c_byte({a, 1'b1}, 1'b1, q0);
         i2c_byte(8'hFF, 1'b0, q1);
         i2c_byte(8'hFF, 1'b1, q2);
         i2c_stop();
         rx = {q0[0], q1[8:1], q2[8:1]};
      end
   endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, sn) \
   begin \
      comparisons++; \
      if ((sn) !== (ex)) begin \
         err_total++; \
         $display("wrong value %s expected %h seen %h", nm, ex, sn); \
      end \
   end
module testbench;
   logic        mclk_in, rst_in, update_tick_in;
   logic [15:0] pressure_in, rx;
   logic [3:0]  strap_code_in;
   logic [16:0] rd_word;
   logic [2:0]  nak;
   logic [7:0]  prev;
   int          err_total, comparisons;
   wire         select_line_n_in, sck_in, mosi_in, sda_in, sda_pull;
   wire         miso_out, miso_oe_out, sda_out, sda_oe_out;
   wire         data_available_pin_out, spi_mode_out, i2c_mode_out;
   wire         settled_out, wdog_en_out, notch_en_out;
   wire  [2:0]  range_out, bw_out;
   wire  [7:0]  rate_out, mode_w;
   wire  [6:0]  i2c_addr_out;
   logic [31:0] rows [2] = '{32'h8001_0C00, 32'h7FFE_5A02};
   assign mode_w = {notch_en_out, bw_out, wdog_en_out, range_out};
   // Open-drain line with pull-up
   assign sda_in = (sda_oe_out ? sda_out : 1'b1) & ~sda_pull;
   psh_port #(.DETECT_CYC(23'h32), .SETTLE_CYC(23'hC8)) uut (.mclk_in,
      .rst_in, .select_line_n_in, .sck_in, .mosi_in, .sda_in, .miso_out,
      .miso_oe_out, .sda_out, .sda_oe_out, .data_available_pin_out,
      .pressure_in, .update_tick_in, .strap_code_in, .spi_mode_out,
      .i2c_mode_out, .settled_out, .range_out, .wdog_en_out, .bw_out,
      .notch_en_out, .rate_out, .i2c_addr_out);
   // Deselected output shows the inverse, never a stale bit
   psh_host host (.miso_in(miso_oe_out ? miso_out : ~miso_out), .sda_in,
      .sel_n_out(select_line_n_in),
      .sck_out(sck_in), .mosi_out(mosi_in), .sda_pull_out(sda_pull));
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   task summarize;
      begin
         $display("comparisons %0d err_total %0d", comparisons, err_total);
         if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task start_up(input logic [3:0] strap);
      int n;
      begin
         @(posedge mclk_in);
         #1;
         rst_in = 1'b1;
         strap_code_in = strap;
         repeat (3) @(posedge mclk_in);
         #1;
         rst_in = 1'b0;
         for (n = 0; n < 200 && (spi_mode_out | i2c_mode_out) !== 1'b1;
              n++) begin
            @(posedge mclk_in);
            #1;
         end
         if (n == 200) begin
            err_total++;
            summarize();
         end
      end
   endtask
   task tick;
      begin
         @(posedge mclk_in);
         #1;
         update_tick_in = 1'b1;
         @(posedge mclk_in);
         #1;
         update_tick_in = 1'b0;
         repeat (2) @(posedge mclk_in);
         #1;
      end
   endtask
   task wait_dav;
      int n;
      begin
         for (n = 0; n < 40 && data_available_pin_out !== 1'b1; n++)
            tick();
         `CHK("dav set", 1'b1, data_available_pin_out)
      end
   endtask
   initial begin
      rst_in = 1'b1;
      update_tick_in = 1'b0;
      pressure_in = 16'h0;
      strap_code_in = 4'h0;
      err_total = 0;
      comparisons = 0;
      start_up(4'h0);
      `CHK("spi mode", 1'b1, spi_mode_out)
      prev = 8'hF3;
      for (int r = 0; r < 2; r++) begin
         pressure_in = rows[r][31:16];
         host.spi_xfer(rows[r][15:0], rx);
         `CHK("spi rx", rows[r][31:16], rx)
         `CHK("rate", rows[r][7:0], rate_out)
         `CHK("mode", prev, mode_w)
         prev = rows[r][15:8];
      end
      wait_dav();
      host.spi_xfer(16'h5A02, rx);
      `CHK("dav clear", 1'b0, data_available_pin_out)
      `CHK("mode", 8'h5A, mode_w)
      tick();
      `CHK("dav early", 1'b0, data_available_pin_out)
      tick();
      `CHK("dav due", 1'b1, data_available_pin_out)
      host.i2c_pins();
      for (int s = 0; s <= 10; s++) begin
         start_up(s[3:0]);
         `CHK("i2c mode", 2'b01, {spi_mode_out, i2c_mode_out})
         `CHK("addr", s < 10 ? 7'h28 + s[6:0] : 7'h28, i2c_addr_out)
      end
      host.i2c_write(7'h27, 16'h3C07, nak);
      `CHK("foreign ack", 3'b111, nak)
      `CHK("rate kept", 8'h1C, rate_out)
      host.i2c_write(7'h28, 16'h3C07, nak);
      `CHK("ack", 3'b000, nak)
      `CHK("rate", 8'h07, rate_out)
      `CHK("mode", 8'hF3, mode_w)
      wait_dav();
      pressure_in = 16'hA55A;
      host.i2c_read(7'h28, rd_word);
      `CHK("i2c rx", {1'b0, 16'hA55A}, rd_word)
      `CHK("dav clear", 1'b0, data_available_pin_out)
      summarize();
   end
endmodule
`default_nettype wire
